// ==== hdl/fsp_status.sv ====
// Three-byte flash status register with write gating and op launch.
// Assumes a decoder gives one whole command per cycle with its byte-end flag.
`timescale 1ns/10ps

module fsp_status (
	// Clock and power-cycle reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// Decoded command.
	input  wire logic        cmdValid,
	input  wire logic [7:0]  cmdCode,
	input  wire logic        cmdAligned,
	input  wire logic [7:0]  cmdData,
	input  wire logic [23:0] cmdAddr,
	// Pins and engine feedback.
	input  wire logic        wpPin,
	input  wire logic        highPerfMode,
	input  wire logic        opDone,
	// Status read.
	input  wire logic [1:0]  rdSel,
	output logic [7:0]       rdData,
	// Status fields.
	output logic             writeInProgress,
	output logic             writeEnableLatch,
	output logic             quadEnable,
	output logic [1:0]       driveStrength,
	output logic [2:0]       securityLock,
	output logic             eraseSuspendedFlag,
	output logic             programSuspendedFlag,
	// Operation launch.
	output logic             progStart,
	output logic             eraseStart,
	output logic             chipEraseStart,
	output logic [23:0]      opAddr
);
	fsp_pkg::fsp_state_type stateReg, stateNext;
	logic [3:0]  srwCntReg, srwCntNext;
	logic        welReg, welNext;
	logic [4:0]  bpReg, bpNext;
	logic        cmpReg, cmpNext;
	logic        quadReg, quadNext;
	logic [2:0]  secReg, secNext;
	logic        lockLoReg, lockLoNext;
	logic        lockHiReg, lockHiNext;
	logic [1:0]  drvReg, drvNext;
	logic        eraSusReg, eraSusNext;
	logic        progSusReg, progSusNext;
	logic [7:0]  rdDataReg, rdDataNext;
	logic        progReg, progNext;
	logic        eraseReg, eraseNext;
	logic        chipReg, chipNext;
	logic [23:0] opAddrReg, opAddrNext;
	logic [23:0] statusWord;
	logic        addrProtected;
	logic        srWritable;
	logic        idle;
	logic        isProg;
	logic        isWipe;
	logic        isChip;
	logic        isSrWrite;
	logic        writeOk;

	fsp_protect_map protMap (
		.blockProt         (bpReg),
		.complementProtect (cmpReg),
		.addr              (cmdAddr),
		.isProtected       (addrProtected)
	);

	fsp_sr_lock srLock (
		.statusLockHi (lockHiReg),
		.statusLockLo (lockLoReg),
		.quadEnable   (quadReg),
		.wpPin        (wpPin),
		.srWritable   (srWritable)
	);

	// Status word in three bytes; reserved positions are tied low.
	always_comb begin
		statusWord = 24'h000000;
		statusWord[fsp_pkg::POS_BUSY] = (stateReg != fsp_pkg::ST_IDLE);
		statusWord[fsp_pkg::POS_LATCH] = welReg;
		statusWord[fsp_pkg::POS_BP_HI:fsp_pkg::POS_BP_LO] = bpReg;
		statusWord[fsp_pkg::POS_LOCK_LO] = lockLoReg;
		statusWord[8 + fsp_pkg::POS_LOCK_HI] = lockHiReg;
		statusWord[8 + fsp_pkg::POS_QUAD] = quadReg;
		statusWord[8 + fsp_pkg::POS_PROG_SUS] = progSusReg;
		statusWord[8 + fsp_pkg::POS_SEC_HI:8 + fsp_pkg::POS_SEC_LO] = secReg;
		statusWord[8 + fsp_pkg::POS_CMP] = cmpReg;
		statusWord[8 + fsp_pkg::POS_ERA_SUS] = eraSusReg;
		statusWord[16 + fsp_pkg::POS_HPF] = highPerfMode;
		statusWord[16 + fsp_pkg::POS_DRV_HI:16 + fsp_pkg::POS_DRV_LO] = drvReg;
	end

	// Command classes and the common write gate.
	always_comb begin
		idle = (stateReg == fsp_pkg::ST_IDLE);
		isProg = (cmdCode == fsp_pkg::CMD_PAGE_PROG) || (cmdCode == fsp_pkg::CMD_QUAD_PROG)
			|| (cmdCode == fsp_pkg::CMD_FAST_PROG);
		isWipe = (cmdCode == fsp_pkg::CMD_SECT_WIPE) || (cmdCode == fsp_pkg::CMD_BLK32_WIPE)
			|| (cmdCode == fsp_pkg::CMD_BLK64_WIPE);
		isChip = (cmdCode == fsp_pkg::CMD_CHIP_WIPE_A) || (cmdCode == fsp_pkg::CMD_CHIP_WIPE_B);
		isSrWrite = (cmdCode == fsp_pkg::CMD_SR_WRITE1) || (cmdCode == fsp_pkg::CMD_SR_WRITE2)
			|| (cmdCode == fsp_pkg::CMD_SR_WRITE3);
		writeOk = cmdValid && cmdAligned && idle && welReg;
	end

	// Next state of every field. Busy commands other than suspend
	// are dropped, since the array engine cannot take two jobs at once.
	always_comb begin
		stateNext = stateReg;
		srwCntNext = srwCntReg;
		welNext = welReg;
		bpNext = bpReg;
		cmpNext = cmpReg;
		quadNext = quadReg;
		secNext = secReg;
		lockLoNext = lockLoReg;
		lockHiNext = lockHiReg;
		drvNext = drvReg;
		eraSusNext = eraSusReg;
		progSusNext = progSusReg;
		progNext = 1'b0;
		eraseNext = 1'b0;
		chipNext = 1'b0;
		opAddrNext = opAddrReg;
		case (stateReg)
			fsp_pkg::ST_SRWRITE: begin
				if (srwCntReg == fsp_pkg::SRW_LAST)
					stateNext = fsp_pkg::ST_IDLE;
				else
					srwCntNext = srwCntReg + 4'h1;
			end
			fsp_pkg::ST_PROGRAM,
			fsp_pkg::ST_ERASE: begin
				if (opDone)
					stateNext = fsp_pkg::ST_IDLE;
			end
			default: ;
		endcase
		if (cmdValid && cmdAligned && idle) begin
			if (cmdCode == fsp_pkg::CMD_LATCH_SET)
				welNext = 1'b1;
			else if (cmdCode == fsp_pkg::CMD_LATCH_CLEAR)
				welNext = 1'b0;
		end
		if (writeOk && isSrWrite && srWritable) begin
			welNext = 1'b0;
			stateNext = fsp_pkg::ST_SRWRITE;
			srwCntNext = 4'h0;
			case (cmdCode)
				fsp_pkg::CMD_SR_WRITE1: begin
					bpNext = cmdData[fsp_pkg::POS_BP_HI:fsp_pkg::POS_BP_LO];
					lockLoNext = cmdData[fsp_pkg::POS_LOCK_LO];
				end
				fsp_pkg::CMD_SR_WRITE2: begin
					lockHiNext = cmdData[fsp_pkg::POS_LOCK_HI];
					quadNext = cmdData[fsp_pkg::POS_QUAD];
					secNext = secReg | cmdData[fsp_pkg::POS_SEC_HI:fsp_pkg::POS_SEC_LO];
					cmpNext = cmdData[fsp_pkg::POS_CMP];
				end
				default: begin
					drvNext = cmdData[fsp_pkg::POS_DRV_HI:fsp_pkg::POS_DRV_LO];
				end
			endcase
		end
		if (writeOk && (isProg || isWipe) && !addrProtected) begin
			welNext = 1'b0;
			stateNext = isProg ? fsp_pkg::ST_PROGRAM : fsp_pkg::ST_ERASE;
			progNext = isProg;
			eraseNext = isWipe;
			opAddrNext = cmdAddr;
		end
		if (writeOk && isChip && bpReg[2:0] == fsp_pkg::LVL_NONE && !cmpReg) begin
			welNext = 1'b0;
			stateNext = fsp_pkg::ST_ERASE;
			chipNext = 1'b1;
			opAddrNext = 24'h000000;
		end
		// Suspend parks a running program or erase; resume clears both flags and restores the program if parked, else the erase.
		if (cmdValid && cmdAligned && cmdCode == fsp_pkg::CMD_SUSPEND) begin
			if (stateReg == fsp_pkg::ST_ERASE) begin
				eraSusNext = 1'b1;
				stateNext = fsp_pkg::ST_IDLE;
			end else if (stateReg == fsp_pkg::ST_PROGRAM) begin
				progSusNext = 1'b1;
				stateNext = fsp_pkg::ST_IDLE;
			end
		end
		if (cmdValid && cmdAligned && cmdCode == fsp_pkg::CMD_RESUME && idle) begin
			eraSusNext = 1'b0;
			progSusNext = 1'b0;
			if (progSusReg)
				stateNext = fsp_pkg::ST_PROGRAM;
			else if (eraSusReg)
				stateNext = fsp_pkg::ST_ERASE;
		end
		case (rdSel)
			fsp_pkg::SEL_LOW: rdDataNext = statusWord[7:0];
			fsp_pkg::SEL_MID: rdDataNext = statusWord[15:8];
			fsp_pkg::SEL_HIGH: rdDataNext = statusWord[23:16];
			default: rdDataNext = 8'h00;
		endcase
	end

	// Reset stands for a power cycle: the temporary lock-down falls away.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stateReg <= fsp_pkg::ST_IDLE;
			srwCntReg <= 4'h0;
			welReg <= 1'b0;
			bpReg <= fsp_pkg::RST_BP;
			cmpReg <= fsp_pkg::RST_CMP;
			quadReg <= fsp_pkg::RST_QUAD;
			secReg <= fsp_pkg::RST_SEC;
			lockLoReg <= fsp_pkg::RST_LOCKL;
			lockHiReg <= fsp_pkg::RST_LOCKH & fsp_pkg::RST_LOCKL;
			drvReg <= fsp_pkg::RST_DRV;
			eraSusReg <= 1'b0;
			progSusReg <= 1'b0;
			rdDataReg <= 8'h00;
			progReg <= 1'b0;
			eraseReg <= 1'b0;
			chipReg <= 1'b0;
			opAddrReg <= 24'h000000;
		end else begin
			stateReg <= stateNext;
			srwCntReg <= srwCntNext;
			welReg <= welNext;
			bpReg <= bpNext;
			cmpReg <= cmpNext;
			quadReg <= quadNext;
			secReg <= secNext;
			lockLoReg <= lockLoNext;
			lockHiReg <= lockHiNext;
			drvReg <= drvNext;
			eraSusReg <= eraSusNext;
			progSusReg <= progSusNext;
			rdDataReg <= rdDataNext;
			progReg <= progNext;
			eraseReg <= eraseNext;
			chipReg <= chipNext;
			opAddrReg <= opAddrNext;
		end
	end

	// Outputs straight from flops, except busy, which is decoded from the state register.
	assign rdData = rdDataReg;
	assign writeInProgress = statusWord[fsp_pkg::POS_BUSY];
	assign writeEnableLatch = welReg;
	assign quadEnable = quadReg;
	assign driveStrength = drvReg;
	assign securityLock = secReg;
	assign eraseSuspendedFlag = eraSusReg;
	assign programSuspendedFlag = progSusReg;
	assign progStart = progReg;
	assign eraseStart = eraseReg;
	assign chipEraseStart = chipReg;
	assign opAddr = opAddrReg;

	// Checks on the command gating and status fields.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_srw_busy_time: assert property (
		$rose(stateReg == fsp_pkg::ST_SRWRITE) |->
		writeInProgress[*5] ##1 !writeInProgress)
		else $error("Status write busy time is wrong.");
	chk_latch_refuses: assert property (
		cmdValid && !welReg && (isSrWrite || isProg || isWipe || isChip) |=>
		!progStart && !eraseStart && !chipEraseStart && $stable(bpReg))
		else $error("Command ran with the latch clear.");
	chk_prot_blocks_op: assert property (
		progStart || eraseStart |-> !$past(addrProtected))
		else $error("Protected address was launched.");
	chk_lock_holds_bits: assert property (
		cmdValid && isSrWrite && !srWritable |=>
		$stable(bpReg) && $stable(lockLoReg) && $stable(cmpReg))
		else $error("Locked status register changed.");
	chk_chip_wipe_guard: assert property (
		chipEraseStart |-> $past(bpReg[2:0]) == fsp_pkg::LVL_NONE && !$past(cmpReg))
		else $error("Chip erase ran under protection.");
	chk_otp_sticky: assert property (
		(secReg & $past(secReg)) == $past(secReg))
		else $error("Security lock bit cleared.");
	chk_resume_clears: assert property (
		cmdValid && cmdAligned && cmdCode == fsp_pkg::CMD_RESUME && idle |=>
		!eraseSuspendedFlag && !programSuspendedFlag)
		else $error("Resume left a suspend flag set.");
	chk_latch_drops: assert property (
		progStart || eraseStart || chipEraseStart |-> !writeEnableLatch)
		else $error("Latch still set after launch.");
	chk_unaligned_drop: assert property (
		cmdValid && !cmdAligned |=> $stable(welReg) && !progStart && !eraseStart
		&& !chipEraseStart && $stable(drvReg))
		else $error("Unaligned command took effect.");
	chk_reserved_zero: assert property (
		rdSel == fsp_pkg::SEL_HIGH |=> rdData[7] == 1'b0 && rdData[3:0] == 4'h0)
		else $error("Reserved status bit read nonzero.");

	cov_srw_done: cover property ($fell(stateReg == fsp_pkg::ST_SRWRITE));
	cov_erase_susp: cover property ($rose(eraseSuspendedFlag));
	cov_chip_wipe: cover property (chipEraseStart);
	cov_prot_refuse: cover property (writeOk && isWipe && addrProtected);
endmodule : fsp_status

// ==== hdl/fsp_pkg.sv ====
// Constants for the flash status and protection block.
// Assumes a command decoder that hands over whole commands, one per cycle.

package fsp_pkg;
	// Command codes.
	localparam logic [7:0] CMD_LATCH_SET   = 8'h06;
	localparam logic [7:0] CMD_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] CMD_SR_WRITE1   = 8'h01;
	localparam logic [7:0] CMD_SR_WRITE2   = 8'h31;
	localparam logic [7:0] CMD_SR_WRITE3   = 8'h11;
	localparam logic [7:0] CMD_PAGE_PROG   = 8'h02;
	localparam logic [7:0] CMD_QUAD_PROG   = 8'h32;
	localparam logic [7:0] CMD_FAST_PROG   = 8'hF2;
	localparam logic [7:0] CMD_SECT_WIPE   = 8'h20;
	localparam logic [7:0] CMD_BLK32_WIPE  = 8'h52;
	localparam logic [7:0] CMD_BLK64_WIPE  = 8'hD8;
	localparam logic [7:0] CMD_CHIP_WIPE_A = 8'h60;
	localparam logic [7:0] CMD_CHIP_WIPE_B = 8'hC7;
	localparam logic [7:0] CMD_SUSPEND     = 8'h75;
	localparam logic [7:0] CMD_RESUME      = 8'h7A;

	// Status read byte selects.
	localparam logic [1:0] SEL_LOW  = 2'h0;
	localparam logic [1:0] SEL_MID  = 2'h1;
	localparam logic [1:0] SEL_HIGH = 2'h2;

	// Field positions within each status byte.
	localparam int POS_BUSY     = 0;
	localparam int POS_LATCH    = 1;
	localparam int POS_BP_LO    = 2;
	localparam int POS_BP_HI    = 6;
	localparam int POS_LOCK_LO  = 7;
	localparam int POS_LOCK_HI  = 0;
	localparam int POS_QUAD     = 1;
	localparam int POS_PROG_SUS = 2;
	localparam int POS_SEC_LO   = 3;
	localparam int POS_SEC_HI   = 5;
	localparam int POS_CMP      = 6;
	localparam int POS_ERA_SUS  = 7;
	localparam int POS_HPF      = 4;
	localparam int POS_DRV_LO   = 5;
	localparam int POS_DRV_HI   = 6;

	// Non-volatile reset values (stand-ins for stored cells).
	localparam logic [4:0] RST_BP    = 5'h00;
	localparam logic       RST_CMP   = 1'b0;
	localparam logic       RST_QUAD  = 1'b0;
	localparam logic [2:0] RST_SEC   = 3'h0;
	localparam logic       RST_LOCKL = 1'b0;
	localparam logic       RST_LOCKH = 1'b0;
	localparam logic [1:0] RST_DRV   = 2'h1;

	// Protection map geometry.
	localparam logic [23:0] ADDR_MAX     = 24'h3FFFFF; // Last byte of the 4 MB array.
	localparam logic [4:0]  SHIFT_SMALL  = 5'h0C;
	localparam logic [4:0]  SHIFT_LARGE  = 5'h10;
	localparam logic [2:0]  LVL_NONE     = 3'h0;
	localparam logic [2:0]  LVL_ALL      = 3'h7;
	localparam logic [2:0]  LVL_SMALLCAP = 3'h4;

	// Status write time and its cycle count at 40 ns per clock.
	localparam int CLK_PERIOD_NS = 40;
	localparam int SRW_TIME_NS   = 200;
	localparam int SRW_CYCLES    = (SRW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SRW_LAST = 4'(SRW_CYCLES - 1);

	typedef enum logic [1:0] {ST_IDLE, ST_SRWRITE, ST_PROGRAM, ST_ERASE} fsp_state_type;
endpackage : fsp_pkg

// ==== hdl/fsp_protect_map.sv ====
// Array protection decode from the block-protect field and complement bit.
// Assumes a 4 MB array with 24-bit byte addresses.
`timescale 1ns/10ps

module fsp_protect_map (
	// Protection setting.
	input  wire logic [4:0]  blockProt,
	input  wire logic        complementProtect,
	// Address under test.
	input  wire logic [23:0] addr,
	output logic             isProtected
);
	logic [2:0]  level;
	logic [4:0]  shift;
	logic [23:0] mask;
	logic        inRegion;
	logic        plainHit;

	// Region size doubles per level; fine granularity caps at 32 KB.
	always_comb begin
		level = (blockProt[4] && blockProt[2]) ? fsp_pkg::LVL_SMALLCAP : blockProt[2:0];
		shift = (blockProt[4] ? fsp_pkg::SHIFT_SMALL : fsp_pkg::SHIFT_LARGE)
			+ 5'(level) - 5'h01;
		mask = ~(fsp_pkg::ADDR_MAX << shift);
		inRegion = blockProt[3] ? ((addr & ~mask) == 24'h000000)
			: ((addr | mask) == fsp_pkg::ADDR_MAX);
		if (blockProt[2:0] == fsp_pkg::LVL_NONE)
			plainHit = 1'b0;
		else if (blockProt[2:0] == fsp_pkg::LVL_ALL)
			plainHit = 1'b1;
		else
			plainHit = inRegion;
		isProtected = plainHit ^ complementProtect;
	end
endmodule : fsp_protect_map

// ==== hdl/fsp_sr_lock.sv ====
// Status register write permission from the lock bits and protect pin.
// Assumes the protect pin is synchronous; with quad enabled it is data.
`timescale 1ns/10ps

module fsp_sr_lock (
	// Lock state.
	input  wire logic statusLockHi,
	input  wire logic statusLockLo,
	input  wire logic quadEnable,
	input  wire logic wpPin,
	output logic      srWritable
);
	logic pinLevel;

	// A pin serving as a data line cannot lock, so it counts as high.
	always_comb begin
		pinLevel = quadEnable | wpPin;
		srWritable = !statusLockHi && (!statusLockLo || pinLevel);
	end
endmodule : fsp_sr_lock

// ==== test/fsp_host_model.sv ====
// Host-side partner: issues whole decoded commands and plays the job engine.
// Assumes the bench calls issue and finish by hierarchical reference.
`timescale 1ns/10ps

module fsp_host_model (
	// Clock and launches seen from the block.
	input  wire logic   clk,
	input  wire logic   jobStart,
	// Command port and engine feedback.
	output logic        cmdValid,
	output logic [7:0]  cmdCode,
	output logic        cmdAligned,
	output logic [7:0]  cmdData,
	output logic [23:0] cmdAddr,
	output logic        opDone
);
	int engDelay = 3;
	bit engHold  = 1'b0;

	// Idle port at time zero.
	initial begin
		{cmdValid, cmdCode, cmdAligned, cmdData, cmdAddr, opDone} = '0;
	end

	// One command held for exactly one taking edge; afterwards the idle bus
	// shows inverted values so a stale command can never pass for a new one.
	task automatic issue(input logic [7:0] c, d, input logic [23:0] a, input logic al);
		@(posedge clk);
		#1 {cmdValid, cmdCode, cmdData, cmdAddr, cmdAligned} = {1'b1, c, d, a, al};
		@(posedge clk);
		#1 {cmdValid, cmdCode, cmdData, cmdAddr, cmdAligned} = {1'b0, ~c, ~d, ~a, ~al};
	endtask : issue

	// One-cycle job completion pulse.
	task automatic finish();
		@(posedge clk);
		#1 opDone = 1'b1;
		@(posedge clk);
		#1 opDone = 1'b0;
	endtask : finish

	// Engine: a launched job ends after engDelay cycles unless held.
	initial forever begin
		@(posedge clk);
		#2 if (jobStart && !engHold) begin
			repeat (engDelay) @(posedge clk);
			finish();
		end
	end
endmodule : fsp_host_model

// ==== test/flash_status_and_protection_tb.sv ====
// Self-checking bench for the flash status and protection block.
// Assumes the host model drives commands; the bench drives pins and reads.
`timescale 1ns/10ps

module flash_status_and_protection_tb;
	logic        clk, rst, wpPin, highPerfMode, cmdValid, cmdAligned, opDone, jobStart;
	logic [7:0]  cmdCode, cmdData, rdData;
	logic [23:0] cmdAddr, opAddr;
	logic [1:0]  rdSel, driveStrength;
	logic [2:0]  securityLock;
	logic        writeInProgress, writeEnableLatch, quadEnable, progStart, eraseStart;
	logic        chipEraseStart, eraseSuspendedFlag, programSuspendedFlag;
	logic [15:0] lfsr = 16'h7DED;
	int          bad_count, n_compared, cycles;
	int          bp, cmp, quad, sec, lkl, lkh, drv, es, ps, write_enable_latch, job;
	logic [23:0] edges [10] = '{24'h000FFF, 24'h001000, 24'h007FFF, 24'h008000,
		24'h1FFFFF, 24'h200000, 24'h3EFFFF, 24'h3F8000, 24'h3FEFFF, 24'h3FFFFF};
	logic [7:0]  ops [6] = '{8'h02, 8'h32, 8'hF2, 8'h20, 8'h52, 8'hD8};
	logic [7:0]  wr [3] = '{8'h01, 8'h31, 8'h11};
	int          msk [3] = '{'h7F, 'hFE, 'hFF};

	assign jobStart = progStart | eraseStart | chipEraseStart;

	fsp_status u_dut (.clk, .rst, .cmdValid, .cmdCode, .cmdAligned, .cmdData, .cmdAddr,
		.wpPin, .highPerfMode, .opDone, .rdSel, .rdData, .writeInProgress,
		.writeEnableLatch, .quadEnable, .driveStrength, .securityLock, .eraseSuspendedFlag,
		.programSuspendedFlag, .progStart, .eraseStart, .chipEraseStart, .opAddr);

	fsp_host_model u_host (.clk, .jobStart, .cmdValid, .cmdCode, .cmdAligned, .cmdData,
		.cmdAddr, .opDone);

	// 25 MHz clock.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Hang guard; the whole run needs well under ten thousand cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			conclude();
		end
	end

	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], ^(lfsr & 16'hB400)};
		return lfsr;
	endfunction : rnd

	// Reference decode of the protected region; complement inverts it.
	function automatic bit prot(input int a);
		int l = bp & 7;
		int sz = bp >> 4 & 1 ? 1 << (11 + (l > 4 ? 4 : l)) : 1 << (15 + l);
		bit hit = bp >> 3 & 1 ? a < sz : a >= 'h400000 - sz;
		if (l == 0)
			hit = 0;
		if (l == 7)
			hit = 1;
		return hit ^ (cmp != 0);
	endfunction : prot

	function automatic logic [7:0] expByte(input int s);
		case (s)
			0: return 8'((job != 0) | write_enable_latch << 1 | bp << 2 | lkl << 7);
			1: return 8'(lkh | quad << 1 | ps << 2 | sec << 3 | cmp << 6 | es << 7);
			2: return 8'(int'(highPerfMode) << 4 | drv << 5);
			default: return 8'h00;
		endcase
	endfunction : expByte

	task automatic compare(input logic [23:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : compare

	// Power-cycle values of the reference.
	task automatic clearModel();
		{bp, cmp, quad, sec, lkl, lkh, es, ps, write_enable_latch, job} = '0;
		drv = 1;
	endtask : clearModel

	task automatic powerCycle();
		@(posedge clk);
		#1 rst = 1'b1;
		@(posedge clk);
		#1 rst = 1'b0;
		clearModel();
	endtask : powerCycle

	// Reads all four byte selects, then the field outputs.
	task automatic chk();
		logic [8:0] f;
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			#1 rdSel = 2'(s);
			@(posedge clk);
			#1 compare(rdData, expByte(s));
		end
		f = {quadEnable, driveStrength, securityLock, eraseSuspendedFlag,
			programSuspendedFlag, writeEnableLatch};
		compare(f, {1'(quad), 2'(drv), 3'(sec), 1'(es), 1'(ps), 1'(write_enable_latch)});
	endtask : chk

	task automatic waitIdle(input int want);
		int n = 0;
		while (writeInProgress !== 1'b0 && n < 60) begin
			@(posedge clk);
			#1 n++;
		end
		compare(writeInProgress, 0);
		if (want >= 0)
			compare(n, want);
		job = 0;
	endtask : waitIdle

	// Issues one command and advances the reference; a busy block takes only suspend.
	task automatic cmd(input logic [7:0] c, input int d = 0, input int a = 0, input bit al = 1);
		int st = 0;
		u_host.issue(c, 8'(d), 24'(a), al);
		if (al && (job == 0 || c == 8'h75)) begin
			case (c)
				8'h06: write_enable_latch = 1;
				8'h04: write_enable_latch = 0;
				8'h01, 8'h31, 8'h11: if (write_enable_latch && !lkh && !(lkl && !wpPin && !quad)) begin
					write_enable_latch = 0;
					job = 3;
					if (c == 8'h01) begin
						bp = d >> 2 & 31;
						lkl = d >> 7 & 1;
					end
					if (c == 8'h31) begin
						lkh = d & 1;
						quad = d >> 1 & 1;
						sec |= d >> 3 & 7;
						cmp = d >> 6 & 1;
					end
					if (c == 8'h11)
						drv = d >> 5 & 3;
				end
				8'h02, 8'h32, 8'hF2, 8'h20, 8'h52, 8'hD8: if (write_enable_latch && !prot(a)) begin
					write_enable_latch = 0;
					st = (c == 8'h02 || c == 8'h32 || c == 8'hF2) ? 1 : 2;
					job = st;
				end
				8'h60, 8'hC7: if (write_enable_latch && !(bp & 7) && !cmp) begin
					write_enable_latch = 0;
					st = 4;
					job = 2;
					a = 0;
				end
				8'h75: if (job == 1 || job == 2) begin
					ps = job == 1;
					es = job == 2;
					job = 0;
				end
				8'h7A: if (es || ps) begin
					job = ps ? 1 : 2;
					{es, ps} = '0;
				end
				default: ;
			endcase
		end
		compare({progStart, eraseStart, chipEraseStart, writeInProgress},
			{st == 1, st == 2, st == 4, job != 0});
		if (st != 0)
			compare(opAddr, 24'(a));
		if (job == 3 || (st != 0 && !u_host.engHold))
			waitIdle(job == 3 ? 5 : -1);
	endtask : cmd

	task automatic conclude();
		$display("compared=%0d mismatches=%0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// Main sequence.
	initial begin
		rst = 1'b1;
		wpPin = 1'b1;
		highPerfMode = 1'b0;
		rdSel = 2'h0;
		clearModel();
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		chk();
		cmd(8'h01, 8'h7C);
		cmd(8'h20, 0, 24'h001000);
		cmd(8'h06);
		cmd(8'h04, 0, 0, 0);
		cmd(8'h01, 8'h10, 0, 0);
		chk();
		cmd(8'h04);
		chk();
		// Random writes to every byte with the lock bits masked off.
		for (int i = 0; i < 12; i++) begin
			cmd(8'h06);
			cmd(wr[i % 3], rnd() & msk[i % 3]);
			chk();
		end
		highPerfMode = 1'b1;
		chk();
		highPerfMode = 1'b0;
		// Every protect code in both map senses, random and boundary addresses.
		for (int k = 0; k < 64; k++) begin
			u_host.engDelay = 2 + k % 9;
			cmd(8'h06);
			cmd(8'h31, k / 32 << 6);
			cmd(8'h06);
			cmd(8'h01, k % 32 << 2);
			cmd(8'h06);
			cmd(ops[k % 6], 0, {rnd(), rnd()} & 'h3FFFFF);
			cmd(8'h06);
			cmd(ops[(k + 3) % 6], 0, edges[rnd() % 10]);
			cmd(8'h06);
			cmd(k % 2 ? 8'h60 : 8'hC7);
			chk();
		end
		// Lock modes against the protect pin, quad mode and power cycling.
		cmd(8'h06);
		cmd(8'h31, 8'h02);
		cmd(8'h06);
		cmd(8'h01, 8'h80);
		wpPin = 1'b0;
		cmd(8'h06);
		cmd(8'h01, 8'h84);
		cmd(8'h06);
		cmd(8'h31, 8'h00);
		cmd(8'h06);
		cmd(8'h01, 8'h88);
		cmd(8'h04);
		chk();
		wpPin = 1'b1;
		cmd(8'h06);
		cmd(8'h01, 8'h88);
		cmd(8'h06);
		cmd(8'h31, 8'h01);
		cmd(8'h06);
		cmd(8'h01, 8'h00);
		cmd(8'h04);
		chk();
		powerCycle();
		chk();
		cmd(8'h06);
		cmd(8'h31, 8'h01);
		cmd(8'h06);
		cmd(8'h11, 8'h60);
		cmd(8'h04);
		chk();
		powerCycle();
		chk();
		// Held erase, then held program: suspend, resume, then completion.
		u_host.engHold = 1'b1;
		for (int j = 0; j < 2; j++) begin
			cmd(8'h06);
			cmd(j ? 8'h02 : 8'h20, 0, 24'h010000);
			cmd(8'h06);
			cmd(8'h75);
			chk();
			cmd(8'h7A);
			chk();
			u_host.finish();
			waitIdle(-1);
		end
		conclude();
	end
endmodule : flash_status_and_protection_tb
